/* File: hmwb_bridge.v */
`timescale 1ns/10ps
`include "hmwb_defs.vh"
// Overview of operation
// - Words move as 21 parallel bits.
// - Address is presented before each data word.
// - Address register spans whole host memory.
// - Program tests busy before register access.
// - Cycle stealer only; host cannot reach processor.
// - Control instruction claims a host cycle, starts traffic.
// - Receive command: increment, clear, fetch word.
// - Receive: busy drops once word loaded.
// - Data read in receive starts next fetch.
// - No word count; program stops transfers.
// - Data write: transmit, increment, write host.
// - Transmit: busy drops after host write.
// - Responds at one wired selector address.
module hmwb_bridge #(
	parameter ADDR_W = `HMWB_ADDR_W,
	parameter [5:0] SEL_ADDR = `HMWB_SEL_ADDR
) (
	// Clock and reset.
	input  wire                    clk_sys_in,
	input  wire                    arst_n_in,
	// Processor selector bus, same clock.
	input  wire                    sel_strobe_in,
	input  wire [5:0]              sel_addr_in,
	input  wire [2:0]              sel_cmd_in,
	input  wire [ADDR_W-1:0]       sel_wdata_in,
	output reg  [ADDR_W-1:0]       sel_rdata_out,
	output reg                     sel_rvalid_out,
	output reg                     busy_out,
	output reg                     recv_mode_out,
	output reg                     par_err_out,
	// Host memory port, pins from the host side.
	output reg                     host_req_out,
	output reg                     host_we_out,
	output reg  [ADDR_W-1:0]       host_addr_out,
	output reg                     host_addr_vld_out,
	output reg  [`HMWB_LINK_W-1:0] host_wdata_out,
	input  wire                    host_ack_in,
	input  wire [`HMWB_LINK_W-1:0] host_rdata_in
);
	// ****************************************************************
	// State codes.
	// ****************************************************************
	localparam [1:0] ST_IDLE = 2'h0;  // Waiting for a command.
	localparam [1:0] ST_ADDR = 2'h1;  // Address alone on the link.
	localparam [1:0] ST_XFER = 2'h2;  // Word time stolen, await ack.
	localparam [1:0] ST_DRN  = 2'h3;  // Fetched word entering data reg.

	reg  [1:0]              st_q;       // Sequencer state.
	reg  [ADDR_W-1:0]       addr_q;     // Host address register.
	reg  [`HMWB_DATA_W-1:0] data_q;     // Data register.
	reg                     ack_m_q;    // Ack synchroniser, first stage.
	reg                     ack_s_q;    // Ack synchroniser, second stage.
	reg                     ack_p_q;    // Previous synchronised ack.
	reg  [`HMWB_LINK_W-1:0] rd_m_q;     // Read data, first stage.
	reg  [`HMWB_LINK_W-1:0] rd_s_q;     // Read data, second stage.
	wire                    hit;        // Command addressed to us.
	wire                    ack_rise;   // Host finished its cycle.
	wire                    buf_rdy;    // Buffer accepts a word.
	wire                    buf_vld;    // Buffer holds a word.
	wire [`HMWB_LINK_W-1:0] buf_dat;    // Word at buffer head.
	wire [ADDR_W+`HMWB_DATA_W-1:0] wd_pad;  // Write data, zero-extended.
	wire [ADDR_W+`HMWB_DATA_W-1:0] rd_pad;  // Data register, zero-extended.
	wire [`HMWB_DATA_W-1:0]        wr_word; // Data word taken on a load.
	wire [ADDR_W-1:0]              rd_word; // Data register as seen on the read bus.

	// Odd parity over a data word, used for both directions.
	function par_of;
		input [`HMWB_DATA_W-1:0] w;
		begin
			par_of = ~^w;
		end
	endfunction

	// Next host address; the bridge steps before every access.
	function [ADDR_W-1:0] step_addr;
		input [ADDR_W-1:0] a;
		begin
			step_addr = a + {{(ADDR_W-1){1'b0}}, 1'b1};
		end
	endfunction

	// Pad before cutting so any bus width elaborates; a bus narrower than
	// the data word loses the upper data bits, which is the user's trade.
	assign wd_pad  = {{`HMWB_DATA_W{1'b0}}, sel_wdata_in};
	assign rd_pad  = {{ADDR_W{1'b0}}, data_q};
	assign wr_word = wd_pad[`HMWB_DATA_W-1:0];
	assign rd_word = rd_pad[ADDR_W-1:0];

	// Only our wired selector address is decoded, so up to 64 units, one per 6-bit address, may share the bus.
	assign hit      = sel_strobe_in && (sel_addr_in == SEL_ADDR);
	assign ack_rise = ack_s_q && !ack_p_q;

	// ****************************************************************
	// Two-flop synchronisers on the host pins.
	// ****************************************************************
	// Read data stays still while ack is high, so its two stages line up
	// with the ack stages and the word is stable when the edge is seen.
	always @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ack_m_q <= 1'b0;
			ack_s_q <= 1'b0;
			ack_p_q <= 1'b0;
			rd_m_q  <= {`HMWB_LINK_W{1'b0}};
			rd_s_q  <= {`HMWB_LINK_W{1'b0}};
		end else begin
			ack_m_q <= host_ack_in;
			ack_s_q <= ack_m_q;
			ack_p_q <= ack_s_q;
			rd_m_q  <= host_rdata_in;
			rd_s_q  <= rd_m_q;
		end
	end

	// ****************************************************************
	// Fetched words pass a two-entry buffer into the data register.
	// ****************************************************************
	hmwb_skid #(
		.WIDTH         (`HMWB_LINK_W)
	) u_skid (
		.clk_sys_in    (clk_sys_in),
		.arst_n_in     (arst_n_in),
		.in_valid_in   (ack_rise && (st_q == ST_XFER) && recv_mode_out),
		.in_ready_out  (buf_rdy),
		.in_data_in    (rd_s_q),
		.out_valid_out (buf_vld),
		.out_ready_in  (st_q == ST_DRN),
		.out_data_out  (buf_dat)
	);

	// ****************************************************************
	// Command decode and host access sequencer.
	// ****************************************************************
	// There is deliberately no host-to-processor path: the host only ever
	// answers our requests, which keeps local memory safe from it.
	always @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_q              <= ST_IDLE;
			addr_q            <= {ADDR_W{1'b0}};
			data_q            <= {`HMWB_DATA_W{1'b0}};
			busy_out          <= 1'b0;
			recv_mode_out     <= 1'b0;
			par_err_out       <= 1'b0;
			sel_rdata_out     <= {ADDR_W{1'b0}};
			sel_rvalid_out    <= 1'b0;
			host_req_out      <= 1'b0;
			host_we_out       <= 1'b0;
			host_addr_out     <= {ADDR_W{1'b0}};
			host_addr_vld_out <= 1'b0;
			host_wdata_out    <= {`HMWB_LINK_W{1'b0}};
		end else begin
			sel_rvalid_out <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					// Commands are taken only while idle; a busy bridge ignores them.
					if (hit) begin
						case (sel_cmd_in)
							`HMWB_CMD_LD_ADDR: begin
								// Program loads first address minus one; any host word reachable.
								addr_q <= sel_wdata_in;
							end
							`HMWB_CMD_RD_ADDR: begin
								sel_rdata_out  <= addr_q;
								sel_rvalid_out <= 1'b1;
							end
							`HMWB_CMD_RECV, `HMWB_CMD_RD_DATA: begin
								// Control command or data read: fetch the next host word.
								// It is also the control instruction that claims the host.
								if (sel_cmd_in == `HMWB_CMD_RD_DATA) begin
									sel_rdata_out  <= rd_word;
									sel_rvalid_out <= 1'b1;
								end
								addr_q        <= step_addr(addr_q);
								host_addr_out <= step_addr(addr_q);
								host_addr_vld_out <= 1'b1;
								recv_mode_out <= 1'b1;
								data_q        <= {`HMWB_DATA_W{1'b0}};
								host_we_out   <= 1'b0;
								busy_out      <= 1'b1;
								st_q          <= ST_ADDR;
							end
							`HMWB_CMD_LD_DATA: begin
								// Write: transmit mode, step address, send word with parity.
								data_q        <= wr_word;
								addr_q        <= step_addr(addr_q);
								host_addr_out <= step_addr(addr_q);
								host_addr_vld_out <= 1'b1;
								host_wdata_out <= {`HMWB_CTL_WR, par_of(wr_word), wr_word};
								recv_mode_out <= 1'b0;
								host_we_out   <= 1'b1;
								busy_out      <= 1'b1;
								st_q          <= ST_ADDR;
							end
							default: begin
								// Unused command codes do nothing.
								st_q <= ST_IDLE;
							end
						endcase
					end
				end
				ST_ADDR: begin
					// Address stood alone one cycle; now steal one word time.
					if (recv_mode_out) begin
						host_wdata_out <= {`HMWB_CTL_RD, 1'b0, {`HMWB_DATA_W{1'b0}}};
					end
					host_req_out <= 1'b1;
					st_q         <= ST_XFER;
				end
				ST_XFER: begin
					// Host ack ends the stolen cycle.
					if (ack_rise && (buf_rdy || !recv_mode_out)) begin
						host_req_out      <= 1'b0;
						host_addr_vld_out <= 1'b0;
						if (recv_mode_out) begin
							st_q <= ST_DRN;
						end else begin
							// Busy clears only once host memory holds the word.
							busy_out <= 1'b0;
							st_q     <= ST_IDLE;
						end
					end
				end
				ST_DRN: begin
					if (buf_vld) begin
						data_q <= buf_dat[`HMWB_DATA_W-1:0];
						// A sticky mismatch flag; cleared only by reset.
						if (par_of(buf_dat[`HMWB_DATA_W-1:0]) != buf_dat[`HMWB_PAR_BIT]) begin
							par_err_out <= 1'b1;
						end
						// Busy clears once the word sits in the data register.
						busy_out <= 1'b0;
						st_q     <= ST_IDLE;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end
	// No word counter exists: each transfer is one program command.
endmodule

/* File: hmwb_defs.vh */
`ifndef HMWB_DEFS_VH
`define HMWB_DEFS_VH
// ****************************************************************
// Bridge widths and constants.
// ****************************************************************
// Local data word width.
`define HMWB_DATA_W      18
// Host link word width: data, parity, two control bits.
`define HMWB_LINK_W      21
// Default host address width.
`define HMWB_ADDR_W      15
// Field positions inside the link word.
`define HMWB_PAR_BIT     18
`define HMWB_CTL_LSB     19
// Control bit codes placed on the link word.
`define HMWB_CTL_RD      2'h1
`define HMWB_CTL_WR      2'h2
// Default selector address of this bridge.
`define HMWB_SEL_ADDR    6'h01
// Selector bus commands.
`define HMWB_CMD_LD_ADDR 3'h1
`define HMWB_CMD_LD_DATA 3'h2
`define HMWB_CMD_RD_DATA 3'h3
`define HMWB_CMD_RECV    3'h4
`define HMWB_CMD_RD_ADDR 3'h5
`endif

/* File: hmwb_skid.v */
`timescale 1ns/10ps
`include "hmwb_defs.vh"
// ****************************************************************
// Two-entry buffer with valid and ready on both sides.
// ****************************************************************
module hmwb_skid #(
	parameter WIDTH = 21
) (
	// Clock and reset.
	input  wire             clk_sys_in,
	input  wire             arst_n_in,
	// Filling side.
	input  wire             in_valid_in,
	output wire             in_ready_out,
	input  wire [WIDTH-1:0] in_data_in,
	// Draining side.
	output wire             out_valid_out,
	input  wire             out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem_q [0:1];   // Two storage words.
	reg             wp_q;          // Write pointer.
	reg             rp_q;          // Read pointer.
	reg [1:0]       cnt_q;         // Occupancy, zero to two.
	wire            push;          // Word taken in.
	wire            pop;           // Word handed out.

	assign in_ready_out  = (cnt_q != 2'h2);
	assign out_valid_out = (cnt_q != 2'h0);
	assign out_data_out  = mem_q[rp_q];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	// ****************************************************************
	// Pointer and occupancy update; full stalls the filling side.
	// ****************************************************************
	always @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) begin
				wp_q <= ~wp_q;
			end
			if (pop) begin
				rp_q <= ~rp_q;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 2'h1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 2'h1;
			end
		end
	end

	// Storage is written without reset; it is only read while valid.
	always @(posedge clk_sys_in) begin
		if (push) begin
			mem_q[wp_q] <= in_data_in;
		end
	end
endmodule

/* File: hmwb_checker.sv */
`timescale 1ns/10ps
// ********************************************
// Selector and host port checker.
// ********************************************
module hmwb_checker #(
	parameter [5:0] SEL_ADDR = 6'h01
) (
	input wire        clk_sys_in,
	input wire        arst_n_in,
	input wire        sel_strobe_in,
	input wire [5:0]  sel_addr_in,
	input wire [2:0]  sel_cmd_in,
	input wire        sel_rvalid_out,
	input wire        busy_out,
	input wire        recv_mode_out,
	input wire        host_req_out,
	input wire        host_we_out,
	input wire        host_addr_vld_out,
	input wire [20:0] host_wdata_out,
	input wire        host_ack_in
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);
	// A command counts only when this bridge is selected and idle.
	wire take = sel_strobe_in && (sel_addr_in == SEL_ADDR) && !busy_out;
	wire rd_cmd = (sel_cmd_in == 3'h3) || (sel_cmd_in == 3'h5);
	a_busy_from_cmd:
		assert property (take && (sel_cmd_in == 3'h2 || sel_cmd_in == 3'h4) |=> busy_out)
		else $error("busy not raised by host access");
	a_addr_before_req:
		assert property ($rose(host_req_out) |-> $past(host_addr_vld_out) && host_addr_vld_out)
		else $error("request without address shown first");
	a_write_frame:
		assert property (host_req_out && host_we_out |->
			host_wdata_out[20:19] == 2'h2 && ^host_wdata_out[18:0])
		else $error("write link word framing wrong");
	a_read_ctl:
		assert property (host_req_out && !host_we_out |-> host_wdata_out[20:19] == 2'h1)
		else $error("read control bits wrong");
	a_busy_holds:
		assert property (busy_out && host_req_out && !host_ack_in |=> busy_out)
		else $error("busy dropped before host answered");
	a_recv_entry:
		assert property (take && sel_cmd_in == 3'h4 |=> recv_mode_out && busy_out)
		else $error("receive mode not entered");
	a_xmit_entry:
		assert property (take && sel_cmd_in == 3'h2 |=> !recv_mode_out && host_we_out)
		else $error("transmit mode not entered");
	a_foreign_quiet:
		assert property (sel_strobe_in && sel_addr_in != SEL_ADDR && !busy_out |=> !busy_out)
		else $error("bridge answered another address");
	a_rvalid_source:
		assert property (sel_rvalid_out |-> $past(take && rd_cmd))
		else $error("read answer without accepted read");
	a_rvalid_read:
		assert property (take && rd_cmd |=> sel_rvalid_out)
		else $error("accepted read got no answer");
endmodule

/* File: hmwb_host_model.sv */
`timescale 1ns/10ps
// ********************************************
// Host memory behind its cycle stealing port.
// ********************************************
module hmwb_host_model (
	input  wire        clk_sys_in,
	input  wire        host_req_in,
	input  wire        host_we_in,
	input  wire [17:0] host_addr_in,
	input  wire [20:0] host_wdata_in,
	input  wire [3:0]  delay_in,
	input  wire        bad_par_in,
	input  wire        traffic_in,
	output logic       host_ack_out,
	output logic [20:0] host_rdata_out
);
	// Host words, each an 18-bit word with its parity bit and two control bits.
	logic [20:0] mem [0:63];
	logic [20:0] last_q;
	// Traffic flag word left by host software; the value is arbitrary, parity odd.
	localparam logic [20:0] FLAG_WORD = {2'h1, 1'b0, 18'h0F0F1};
	// Seed words carry good odd parity.
	function automatic logic [20:0] seed_word(input int i);
		logic [17:0] d;
		d = 18'h2A5A5 ^ 18'(i);
		return {2'h1, ~^d, d};
	endfunction
	// One process owns memory and outputs, so nothing has two drivers.
	// A request steals one word time; the answer waits delay_in cycles.
	initial begin
		host_ack_out = 1'b0;
		host_rdata_out = 21'h0;
		for (int i = 0; i < 64; i++) mem[i] = seed_word(i);
		forever begin
			@(posedge clk_sys_in);
			// Host software marks pending traffic in its own memory.
			if (traffic_in) mem[63] = FLAG_WORD;
			if (host_req_in) begin
				repeat (delay_in) @(posedge clk_sys_in);
				#1;
				if (host_we_in) mem[host_addr_in[5:0]] = host_wdata_in;
				last_q = mem[host_addr_in[5:0]] ^ {2'h0, bad_par_in, 18'h0};
				host_rdata_out = last_q;
				host_ack_out = 1'b1;
				while (host_req_in) @(posedge clk_sys_in);
				#1;
				host_ack_out = 1'b0;
				// Released data must not look like a held word.
				host_rdata_out = ~last_q;
			end
		end
	end
endmodule

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	// ********************************************
	// Stimulus, design and host model.
	// ********************************************
	logic clk_sys_in, arst_n_in, stb, par_bad, traffic;
	logic [5:0] sadr;
	logic [2:0] scmd;
	logic [17:0] swd, rdat, haddr;
	logic [3:0] dly;
	wire [20:0] hwd, hrd;
	wire rvld, busy, recv, perr, req, we, avld, ack;
	int failures = 0;
	int checks_done = 0;
	int cyc = 0;
	hmwb_bridge #(.ADDR_W(18), .SEL_ADDR(6'h01)) DUT (.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in), .sel_strobe_in(stb), .sel_addr_in(sadr), .sel_cmd_in(scmd),
		.sel_wdata_in(swd), .sel_rdata_out(rdat), .sel_rvalid_out(rvld), .busy_out(busy),
		.recv_mode_out(recv), .par_err_out(perr), .host_req_out(req), .host_we_out(we),
		.host_addr_out(haddr), .host_addr_vld_out(avld), .host_wdata_out(hwd),
		.host_ack_in(ack), .host_rdata_in(hrd));
	hmwb_host_model u_host (.clk_sys_in(clk_sys_in), .host_req_in(req), .host_we_in(we),
		.host_addr_in(haddr), .host_wdata_in(hwd), .delay_in(dly), .bad_par_in(par_bad),
		.traffic_in(traffic),
		.host_ack_out(ack), .host_rdata_out(hrd));
	initial begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	// A hang ends the run as a mismatch.
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			tally_and_finish;
		end
	end
	// ********************************************
	// Shared tasks.
	// ********************************************
	task automatic check(input string what, input logic [20:0] seen, input logic [20:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One strobe cycle, launched and released at falling edges.
	task automatic cmd(input logic [5:0] a, input logic [2:0] c, input logic [17:0] w);
		@(negedge clk_sys_in);
		stb = 1'b1;
		sadr = a;
		scmd = c;
		swd = w;
		@(negedge clk_sys_in);
		stb = 1'b0;
	endtask
	task automatic idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 200) begin
			@(negedge clk_sys_in);
			n++;
		end
		check("idle", {20'h0, busy}, 21'h0);
	endtask
	task automatic tally_and_finish;
		if (failures == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ********************************************
	// Scenarios.
	// ********************************************
	task automatic t_recv;
		check("busy", busy, 1'b0);
		dly = 4'h6;
		cmd(6'h01, 3'h1, 18'h00009);
		cmd(6'h01, 3'h4, 18'h0);
		idle;
		check("recv", recv, 1'b1);
		for (int i = 10; i < 13; i++) begin
			cmd(6'h01, 3'h5, 18'h0);
			check("addr", rdat, 21'(i));
			cmd(6'h01, 3'h3, 18'h0);
			check("data", rdat, u_host.mem[i][17:0]);
			check("busy", busy, 1'b1);
			idle;
		end
	endtask
	task automatic t_xmit;
		logic [17:0] w;
		dly = 4'h1;
		cmd(6'h01, 3'h1, 18'h20013);
		for (int i = 0; i < 3; i++) begin
			w = 18'h15A5A + 18'(i);
			cmd(6'h01, 3'h2, w);
			check("busy", busy, 1'b1);
			idle;
			check("word", u_host.mem[20 + i], {2'h2, ~^w, w});
		end
		check("recv", recv, 1'b0);
		cmd(6'h01, 3'h5, 18'h0);
		check("addr", rdat, 18'h20016);
	endtask
	// A load while busy must be ignored; so must another bridge's command.
	task automatic t_refuse;
		dly = 4'h8;
		cmd(6'h01, 3'h2, 18'h00001);
		cmd(6'h01, 3'h1, 18'h00100);
		cmd(6'h01, 3'h2, 18'h00002);
		idle;
		cmd(6'h01, 3'h5, 18'h0);
		check("addr", rdat, 18'h20017);
		check("kept", u_host.mem[23], {2'h2, 1'b0, 18'h00001});
		cmd(6'h02, 3'h4, 18'h0);
		check("busy", busy, 1'b0);
		check("recv", recv, 1'b0);
	endtask
	// The host leaves a flag word; the program polls it with a receive command.
	task automatic t_poll;
		traffic = 1'b1;
		cmd(6'h01, 3'h1, 18'h0003E);
		cmd(6'h01, 3'h4, 18'h0);
		idle;
		cmd(6'h01, 3'h3, 18'h0);
		check("flag", rdat, 18'h0F0F1);
		idle;
	endtask
	task automatic t_parity;
		check("perr", perr, 1'b0);
		par_bad = 1'b1;
		cmd(6'h01, 3'h1, 18'h00004);
		cmd(6'h01, 3'h4, 18'h0);
		idle;
		check("perr", perr, 1'b1);
		par_bad = 1'b0;
	endtask
	initial begin
		arst_n_in = 1'b0;
		stb = 1'b0;
		sadr = 6'h00;
		scmd = 3'h0;
		swd = 18'h0;
		dly = 4'h1;
		par_bad = 1'b0;
		traffic = 1'b0;
		repeat (8) @(negedge clk_sys_in);
		arst_n_in = 1'b1;
		t_recv;
		t_xmit;
		t_refuse;
		t_poll;
		t_parity;
		tally_and_finish;
	end
endmodule
bind hmwb_bridge hmwb_checker #(.SEL_ADDR(SEL_ADDR)) u_chk (.clk_sys_in(clk_sys_in),
	.arst_n_in(arst_n_in), .sel_strobe_in(sel_strobe_in), .sel_addr_in(sel_addr_in),
	.sel_cmd_in(sel_cmd_in), .sel_rvalid_out(sel_rvalid_out), .busy_out(busy_out),
	.recv_mode_out(recv_mode_out), .host_req_out(host_req_out), .host_we_out(host_we_out),
	.host_addr_vld_out(host_addr_vld_out), .host_wdata_out(host_wdata_out),
	.host_ack_in(host_ack_in));
